/* lsoc_pkg.sv */
// package: register map, field positions, reset values and timing for the 32k osc control block
package lsoc_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_INT_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_INT_TRIM  = 4'h1;
    localparam logic [3:0] ADDR_EXT_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_EVT_CTRL  = 4'h3;
    localparam logic [3:0] ADDR_CFD_CTRL  = 4'h4;
    localparam logic [3:0] ADDR_STATUS    = 4'h5;
    // int/ext control field positions
    localparam int BIT_ENABLE   = 1;
    localparam int BIT_XTAL_SEL = 2;
    localparam int BIT_OUT_32K_ENABLE    = 3;
    localparam int BIT_OUT_1K_ENABLE     = 4;
    localparam int BIT_RUNSTBY  = 6;
    localparam int BIT_ONREQ    = 7;
    // event control and fail detector control fields
    localparam int BIT_FAIL_EO  = 0;
    localparam int BIT_CFD_EN   = 0;
    localparam int BIT_SWBACK   = 1;
    // status fields
    localparam int BIT_INT_RDY  = 0;
    localparam int BIT_EXT_RDY  = 1;
    localparam int BIT_CLK_FAIL = 2;
    localparam int BIT_SAFE_CLK = 3;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [6:0] RST_TRIM = 7'h40;
    // timing
    localparam int CLK_MHZ           = 200;
    localparam int STARTUP_US        = 20;
    localparam int STARTUP_CYC       = STARTUP_US * CLK_MHZ;
    localparam int COMMIT_CYC        = 4;
    localparam int DIV_32K           = 6104;
    localparam int DIV_1K            = 32;
    localparam int FAIL_TIMEOUT_CYC  = 64;
    // cpu power modes
    typedef enum logic [1:0] {
        LSOC_MODE_ACTIVE  = 2'b00,
        LSOC_MODE_IDLE    = 2'b01,
        LSOC_MODE_STANDBY = 2'b11
    } lsoc_mode_e;
endpackage

/* lsoc_osc_core.sv */
// oscillator run model: start-up count, trim commit and 32k/1k tick generation
`timescale 1ns/1ps
module lsoc_osc_core #(
    parameter int STARTUP_CYC = lsoc_pkg::STARTUP_CYC,
    parameter int DIV_32K     = lsoc_pkg::DIV_32K
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       run_in,
    input  wire logic       trim_load_in,
    input  wire logic [6:0] trim_in,
    output logic            ready_out,
    output logic [6:0]      trim_out,
    output logic            tick_32k_out,
    output logic            tick_1k_out
);
    logic [15:0] start_cnt_reg;
    logic [2:0]  commit_cnt_reg;
    logic [15:0] div_reg;
    logic [4:0]  k_reg;

    // start-up: not ready until the count expires after each start
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || !run_in) begin
            start_cnt_reg <= 16'h0000;
        end else if (start_cnt_reg != 16'(STARTUP_CYC)) begin
            start_cnt_reg <= start_cnt_reg + 16'h0001;
        end
    end

    // trim reaches the oscillator only after the commit delay
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            commit_cnt_reg <= 3'h0;
            trim_out       <= lsoc_pkg::RST_TRIM;
        end else if (trim_load_in) begin
            commit_cnt_reg <= 3'(lsoc_pkg::COMMIT_CYC);
        end else if (commit_cnt_reg != 3'h0) begin
            commit_cnt_reg <= commit_cnt_reg - 3'h1;
            if (commit_cnt_reg == 3'h1) begin
                trim_out <= trim_in;
            end
        end
    end

    assign ready_out = run_in && (start_cnt_reg == 16'(STARTUP_CYC))
                       && (commit_cnt_reg == 3'h0) && !trim_load_in;

    // tick dividers run only while the oscillator runs
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || !run_in) begin
            div_reg      <= 16'h0000;
            k_reg        <= 5'h00;
            tick_32k_out <= 1'b0;
            tick_1k_out  <= 1'b0;
        end else begin
            tick_32k_out <= 1'b0;
            tick_1k_out  <= 1'b0;
            if (div_reg == 16'(DIV_32K - 1)) begin
                div_reg      <= 16'h0000;
                tick_32k_out <= 1'b1;
                k_reg        <= k_reg + 5'h01;
                if (k_reg == 5'(lsoc_pkg::DIV_1K - 1)) begin
                    tick_1k_out <= 1'b1;
                end
            end else begin
                div_reg <= div_reg + 16'h0001;
            end
        end
    end
endmodule

/* lsoc_ctrl.sv */
// low-speed 32k oscillator control: registers, run decision, outputs, pads, fail detector
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// - internal oscillator off after power-on reset; enable bit starts and stops it
// - new trim reaches oscillator after the commit delay, ready held low until then; software waits for ready
// - 32.768 kHz output driven only while its enable bit is set
// - 1.024 kHz output driven only while its enable bit is set
// - enable bit clear keeps oscillator stopped in every mode
// - run decision from cpu mode, run-on-request, keep-running-in-standby
// - with run-on-request clear, internal oscillator survives every non-power-on reset
// - start-up interval after power-on or wake from stopped state
// - crystal select routes crystal pads or external clock input
// - fail event output when enabled, suppressed once on safe clock
// - fail detector wakes device; halts per external osc config and request
// ----------------------------------------------------------------
module lsoc_ctrl #(
    parameter int STARTUP_CYC = lsoc_pkg::STARTUP_CYC,
    parameter int DIV_32K     = lsoc_pkg::DIV_32K
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       por_in,
    input  wire logic [1:0] cpu_mode_in,
    input  wire logic       int_req_in,
    input  wire logic       ext_req_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out,
    output logic            int_clk_32k_out,
    output logic            int_clk_1k_out,
    output logic [6:0]      int_trim_out,
    input  wire logic       xtal_in_pad_in,
    output logic            xtal_out_pad_out,
    output logic            xtal_out_pad_oe_out,
    output logic            xtal_in_pad_oe_out,
    input  wire logic       ext_ready_in,
    output logic            ext_osc_run_out,
    output logic            ext_clk_32k_out,
    output logic            ext_clk_1k_out,
    output logic            fail_event_out,
    output logic            fail_wake_out,
    output logic            safe_clk_sel_out
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] int_ctrl_reg;
    logic [6:0] trim_reg;
    logic [7:0] ext_ctrl_reg;
    logic       fail_eo_reg;
    logic [1:0] cfd_ctrl_reg;
    logic       trim_load;
    logic       int_ready;
    logic       int_run;
    logic       tick_32k;
    logic       tick_1k;
    logic       clk_fail_reg;
    logic [6:0] fail_cnt_reg;
    logic       ext_seen_reg;
    logic       ext_run;

    function automatic logic run_decide(input logic       en,
                                        input logic       onreq,
                                        input logic       stby,
                                        input logic [1:0] mode,
                                        input logic       req);
        logic r;
        r = 1'b0;
        if (!en) begin
            r = 1'b0;
        end else if (mode != lsoc_pkg::LSOC_MODE_STANDBY || stby) begin
            r = onreq ? req : 1'b1;
        end else begin
            r = req;
        end
        return r;
    endfunction

    // por clears every control register; other resets keep the int control bits when
    // run-on-request is clear so the oscillator skips start-up again
    always_ff @(posedge ref_clk_in) begin
        if (por_in) begin
            int_ctrl_reg <= lsoc_pkg::RST_CTRL;
        end else if (!rst_b_in) begin
            if (int_ctrl_reg[lsoc_pkg::BIT_ONREQ]) begin
                int_ctrl_reg <= lsoc_pkg::RST_CTRL;
            end
        end else if (reg_wr_in && reg_addr_in == lsoc_pkg::ADDR_INT_CTRL) begin
            int_ctrl_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (por_in) begin
            trim_reg <= lsoc_pkg::RST_TRIM;
        end else if (rst_b_in && trim_load) begin
            trim_reg <= reg_wdata_in[6:0];
        end
    end

    assign trim_load = reg_wr_in && reg_addr_in == lsoc_pkg::ADDR_INT_TRIM;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || por_in) begin
            ext_ctrl_reg <= lsoc_pkg::RST_CTRL;
            fail_eo_reg  <= 1'b0;
            cfd_ctrl_reg <= 2'b00;
        end else if (reg_wr_in) begin
            if (reg_addr_in == lsoc_pkg::ADDR_EXT_CTRL) begin
                ext_ctrl_reg <= reg_wdata_in;
            end else if (reg_addr_in == lsoc_pkg::ADDR_EVT_CTRL) begin
                fail_eo_reg <= reg_wdata_in[lsoc_pkg::BIT_FAIL_EO];
            end else if (reg_addr_in == lsoc_pkg::ADDR_CFD_CTRL) begin
                cfd_ctrl_reg <= reg_wdata_in[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // internal oscillator
    // ----------------------------------------------------------------
    assign int_run = run_decide(int_ctrl_reg[lsoc_pkg::BIT_ENABLE],
                                int_ctrl_reg[lsoc_pkg::BIT_ONREQ],
                                int_ctrl_reg[lsoc_pkg::BIT_RUNSTBY],
                                cpu_mode_in, int_req_in);

    lsoc_osc_core #(
        .STARTUP_CYC (STARTUP_CYC),
        .DIV_32K     (DIV_32K)
    ) u_core (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (!por_in),
        .run_in       (int_run),
        .trim_load_in (trim_load),
        .trim_in      (trim_reg),
        .ready_out    (int_ready),
        .trim_out     (int_trim_out),
        .tick_32k_out (tick_32k),
        .tick_1k_out  (tick_1k)
    );
    // core ready covers start-up (rule 8) and trim commit (rule 2)

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            int_clk_32k_out <= 1'b0;
            int_clk_1k_out  <= 1'b0;
        end else begin
            int_clk_32k_out <= tick_32k && int_ready && int_ctrl_reg[lsoc_pkg::BIT_OUT_32K_ENABLE];
            int_clk_1k_out  <= tick_1k && int_ready && int_ctrl_reg[lsoc_pkg::BIT_OUT_1K_ENABLE];
        end
    end

    // ----------------------------------------------------------------
    // external oscillator pads and outputs
    // ----------------------------------------------------------------
    assign ext_run = run_decide(ext_ctrl_reg[lsoc_pkg::BIT_ENABLE],
                                ext_ctrl_reg[lsoc_pkg::BIT_ONREQ],
                                ext_ctrl_reg[lsoc_pkg::BIT_RUNSTBY],
                                cpu_mode_in, ext_req_in);

    // crystal drives the output pad only in crystal mode; else it is free gpio
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ext_osc_run_out     <= 1'b0;
            xtal_out_pad_oe_out <= 1'b0;
            xtal_out_pad_out    <= 1'b0;
            xtal_in_pad_oe_out  <= 1'b0;
            ext_seen_reg        <= 1'b0;
        end else begin
            ext_osc_run_out     <= ext_run;
            xtal_out_pad_oe_out <= ext_run && ext_ctrl_reg[lsoc_pkg::BIT_XTAL_SEL];
            xtal_out_pad_out    <= !xtal_in_pad_in;
            xtal_in_pad_oe_out  <= 1'b0;
            ext_seen_reg        <= xtal_in_pad_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ext_clk_32k_out <= 1'b0;
            ext_clk_1k_out  <= 1'b0;
        end else begin
            ext_clk_32k_out <= ext_run && ext_ready_in && xtal_in_pad_in && !ext_seen_reg
                               && ext_ctrl_reg[lsoc_pkg::BIT_OUT_32K_ENABLE];
            ext_clk_1k_out  <= ext_run && ext_ready_in && tick_1k
                               && ext_ctrl_reg[lsoc_pkg::BIT_OUT_1K_ENABLE];
        end
    end

    // ----------------------------------------------------------------
    // clock failure detector
    // ----------------------------------------------------------------
    // no pad edge within the timeout while running means a dead clock;
    // halts with the external oscillator so sleep does not look like failure
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in || !cfd_ctrl_reg[lsoc_pkg::BIT_CFD_EN] || !ext_run
            || !ext_ready_in) begin
            fail_cnt_reg <= 7'h00;
        end else if (xtal_in_pad_in != ext_seen_reg) begin
            fail_cnt_reg <= 7'h00;
        end else if (fail_cnt_reg != 7'(lsoc_pkg::FAIL_TIMEOUT_CYC)) begin
            fail_cnt_reg <= fail_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            clk_fail_reg     <= 1'b0;
            safe_clk_sel_out <= 1'b0;
            fail_event_out   <= 1'b0;
            fail_wake_out    <= 1'b0;
        end else begin
            clk_fail_reg   <= fail_cnt_reg == 7'(lsoc_pkg::FAIL_TIMEOUT_CYC);
            fail_wake_out  <= fail_cnt_reg == 7'(lsoc_pkg::FAIL_TIMEOUT_CYC)
                              && !clk_fail_reg;
            // switch to safe clock one cycle after the failure shows
            if (clk_fail_reg) begin
                safe_clk_sel_out <= 1'b1;
            end else if (cfd_ctrl_reg[lsoc_pkg::BIT_SWBACK]) begin
                safe_clk_sel_out <= 1'b0;
            end
            fail_event_out <= fail_eo_reg && clk_fail_reg && !safe_clk_sel_out;
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (reg_addr_in == lsoc_pkg::ADDR_INT_CTRL) begin
                reg_rdata_out <= int_ctrl_reg;
            end else if (reg_addr_in == lsoc_pkg::ADDR_INT_TRIM) begin
                reg_rdata_out <= {1'b0, trim_reg};
            end else if (reg_addr_in == lsoc_pkg::ADDR_EXT_CTRL) begin
                reg_rdata_out <= ext_ctrl_reg;
            end else if (reg_addr_in == lsoc_pkg::ADDR_EVT_CTRL) begin
                reg_rdata_out <= {7'h00, fail_eo_reg};
            end else if (reg_addr_in == lsoc_pkg::ADDR_CFD_CTRL) begin
                reg_rdata_out <= {6'h00, cfd_ctrl_reg};
            end else if (reg_addr_in == lsoc_pkg::ADDR_STATUS) begin
                reg_rdata_out <= {4'h0, safe_clk_sel_out, clk_fail_reg,
                                  ext_ready_in, int_ready};
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule

/* lsoc_ctrl_assertions.sv */
// concurrent checks on the ports of the 32k oscillator control block
`timescale 1ns/1ps
module lsoc_ctrl_assertions #(
    parameter int STARTUP_CYC = 20,
    parameter int DIV_32K     = 8
) (
    input wire logic       ref_clk_in,
    input wire logic       rst_b_in,
    input wire logic       por_in,
    input wire logic [1:0] cpu_mode_in,
    input wire logic       ext_req_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       int_clk_32k_out,
    input wire logic       int_clk_1k_out,
    input wire logic       xtal_out_pad_oe_out,
    input wire logic       xtal_in_pad_oe_out,
    input wire logic       ext_osc_run_out,
    input wire logic       fail_event_out,
    input wire logic       fail_wake_out,
    input wire logic       safe_clk_sel_out
);
    // ----------------------------------------------------------------
    // shadow copies of the control registers
    // ----------------------------------------------------------------
    logic [7:0] int_sh_reg;
    logic [7:0] ext_sh_reg;
    logic       evt_sh_reg;
    // int control survives a plain reset unless run-on-request is set
    always_ff @(posedge ref_clk_in) begin
        if (por_in || (!rst_b_in && int_sh_reg[7]))
            int_sh_reg <= 8'h00;
        else if (rst_b_in && reg_wr_in && reg_addr_in == lsoc_pkg::ADDR_INT_CTRL)
            int_sh_reg <= reg_wdata_in;
    end
    always_ff @(posedge ref_clk_in) begin
        if (por_in || !rst_b_in)
            ext_sh_reg <= 8'h00;
        else if (reg_wr_in && reg_addr_in == lsoc_pkg::ADDR_EXT_CTRL)
            ext_sh_reg <= reg_wdata_in;
    end
    always_ff @(posedge ref_clk_in) begin
        if (por_in || !rst_b_in)
            evt_sh_reg <= 1'b0;
        else if (reg_wr_in && reg_addr_in == lsoc_pkg::ADDR_EVT_CTRL)
            evt_sh_reg <= reg_wdata_in[0];
    end
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in || por_in);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read answer");
    out32_gate_a: assert property (int_clk_32k_out |-> int_sh_reg[3] || $past(int_sh_reg[3]))
        else $error("32k output while its enable is clear");
    out1k_gate_a: assert property (int_clk_1k_out |-> int_sh_reg[4] || $past(int_sh_reg[4]))
        else $error("1k output while its enable is clear");
    rdy_stop_a: assert property (reg_rd_in && reg_addr_in == lsoc_pkg::ADDR_STATUS
        && !int_sh_reg[1] && !$past(int_sh_reg[1]) |=> !reg_rdata_out[0])
        else $error("ready reported with oscillator disabled");
    pad_in_oe_a: assert property (!xtal_in_pad_oe_out)
        else $error("input pad driven");
    pad_out_oe_a: assert property (xtal_out_pad_oe_out |-> ext_sh_reg[2] || $past(ext_sh_reg[2]))
        else $error("output pad driven without crystal select");
    ext_stop_a: assert property (!ext_sh_reg[1] && !$past(ext_sh_reg[1]) |-> !ext_osc_run_out)
        else $error("external osc runs while disabled");
    ext_stby_a: assert property (cpu_mode_in == 2'b11 && $past(cpu_mode_in) == 2'b11
        && !ext_sh_reg[6] && !ext_req_in && !$past(ext_req_in) |=> !ext_osc_run_out)
        else $error("external osc runs in standby without request");
    ext_run_a: assert property (ext_sh_reg[1] && !ext_sh_reg[7] && $past(ext_sh_reg[1])
        && cpu_mode_in != 2'b11 && $past(cpu_mode_in) != 2'b11 && !safe_clk_sel_out
        && !fail_wake_out && !$past(fail_wake_out) |-> ext_osc_run_out)
        else $error("external osc stopped in active mode");
    evt_gate_a: assert property (fail_event_out |-> evt_sh_reg || $past(evt_sh_reg))
        else $error("fail event while event output disabled");
    evt_safe_a: assert property (safe_clk_sel_out && $past(safe_clk_sel_out) |-> !fail_event_out)
        else $error("fail event on the safe clock");
    wake_pulse_a: assert property (fail_wake_out |=> !fail_wake_out)
        else $error("wake pulse longer than one cycle");
    wake_safe_a: assert property (fail_wake_out |-> ##[1:3] safe_clk_sel_out)
        else $error("no safe clock after failure");
endmodule
bind lsoc_ctrl lsoc_ctrl_assertions #(.STARTUP_CYC(STARTUP_CYC), .DIV_32K(DIV_32K)) chk (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .por_in(por_in), .cpu_mode_in(cpu_mode_in),
    .ext_req_in(ext_req_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .int_clk_32k_out(int_clk_32k_out), .int_clk_1k_out(int_clk_1k_out),
    .xtal_out_pad_oe_out(xtal_out_pad_oe_out), .xtal_in_pad_oe_out(xtal_in_pad_oe_out),
    .ext_osc_run_out(ext_osc_run_out), .fail_event_out(fail_event_out),
    .fail_wake_out(fail_wake_out), .safe_clk_sel_out(safe_clk_sel_out));

/* lsoc_xtal_model.sv */
// external 32k crystal model: pad toggling and stable flag after start-up
`timescale 1ns/1ps
module lsoc_xtal_model #(
    parameter int START = 16
) (
    input  wire logic clk_in,
    input  wire logic run_in,
    input  wire logic halt_in,
    output logic      pad_out,
    output logic      ready_out
);
    logic [7:0] cnt_reg = 8'h00;
    logic       pad_reg = 1'b0;
    logic       rdy_reg = 1'b0;
    // a stopped crystal leaves the pad at its last level, which is what the detector sees
    always @(posedge clk_in) begin
        if (!run_in) begin
            cnt_reg <= 8'h00;
            rdy_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg >= 8'(START))
                rdy_reg <= 1'b1;
            if (!halt_in && cnt_reg[1:0] == 2'b11)
                pad_reg <= ~pad_reg;
        end
    end
    assign pad_out   = pad_reg;
    assign ready_out = rdy_reg;
endmodule

/* low_speed_32k_osc_control_tb.sv */
// self-checking bench for the 32k oscillator control block
`timescale 1ns/1ps
module low_speed_32k_osc_control_tb;
    typedef struct packed {
        logic [3:0] wa;
        logic [7:0] wd;
        logic [1:0] md;
        logic       rq;
        logic [7:0] ex;
    } lsoc_row_s;
    logic       clk, rst_b, por, ireq, ereq, wr_s, rd_s, c32, c1, pad, opad_oe, ipad_oe;
    logic       erdy, erun, fev, fwk, safe, halt, e32, xo;
    logic [1:0] mode;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [6:0] trim;
    int         mismatches, checked, n32, n1, ev_seen, wk, ne32;
    // int ctrl writes read back ready (mode 2'b11 is standby); ext and event ctrl writes read back themselves, status and unmapped writes read zero
    lsoc_row_s  rows [12] = '{
        '{lsoc_pkg::ADDR_EXT_CTRL, 8'h04, 2'b00, 1'b0, 8'h04},
        '{lsoc_pkg::ADDR_EVT_CTRL, 8'h01, 2'b00, 1'b0, 8'h01},
        '{lsoc_pkg::ADDR_STATUS, 8'hff, 2'b00, 1'b0, 8'h00},
        '{4'hf, 8'hff, 2'b00, 1'b0, 8'h00},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h02, 2'b00, 1'b0, 8'h01},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h00, 2'b00, 1'b1, 8'h00},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h82, 2'b00, 1'b0, 8'h00},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h82, 2'b01, 1'b1, 8'h01},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h42, 2'b11, 1'b0, 8'h01},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'hc2, 2'b11, 1'b0, 8'h00},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h02, 2'b11, 1'b1, 8'h01},
        '{lsoc_pkg::ADDR_INT_CTRL, 8'h02, 2'b11, 1'b0, 8'h00}};
    lsoc_ctrl #(.STARTUP_CYC(20), .DIV_32K(8)) dut (
        .ref_clk_in(clk), .rst_b_in(rst_b), .por_in(por), .cpu_mode_in(mode),
        .int_req_in(ireq), .ext_req_in(ereq), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .int_clk_32k_out(c32), .int_clk_1k_out(c1), .int_trim_out(trim),
        .xtal_in_pad_in(pad), .xtal_out_pad_out(xo), .xtal_out_pad_oe_out(opad_oe),
        .xtal_in_pad_oe_out(ipad_oe), .ext_ready_in(erdy), .ext_osc_run_out(erun),
        .ext_clk_32k_out(e32), .ext_clk_1k_out(), .fail_event_out(fev),
        .fail_wake_out(fwk), .safe_clk_sel_out(safe));
    lsoc_xtal_model xtal (.clk_in(clk), .run_in(erun), .halt_in(halt), .pad_out(pad),
        .ready_out(erdy));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // counted mid-cycle so registered outputs are settled, not racing their edge
    always @(negedge clk) begin
        ne32 += int'(e32 === 1'b1);
        n32 += int'(c32 === 1'b1);
        n1 += int'(c1 === 1'b1);
        ev_seen += int'(fev === 1'b1);
        wk += int'(fwk === 1'b1);
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task do_reset(input logic p);
        @(posedge clk);
        rst_b <= 1'b0;
        por <= p;
        @(posedge clk);
        rst_b <= 1'b1;
        por <= 1'b0;
    endtask
    // settle, then count ticks over a window that is a whole number of periods
    task tick(input int n, input logic [7:0] e32, input logic [7:0] e1);
        repeat (4) @(posedge clk);
        #1 n32 = 0;
        n1 = 0;
        repeat (n) @(posedge clk);
        #1 chk(8'(n32), e32);
        chk(8'(n1), e1);
    endtask
    task give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
    initial begin
        {rst_b, ireq, ereq, wr_s, rd_s, halt, mode, addr, wdata} = '0;
        ne32 = 0;
        por = 1'b1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        por <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            mode <= rows[i].md;
            ireq <= rows[i].rq;
            ereq <= rows[i].rq;
            repeat (40) @(posedge clk);
            if (rows[i].wa == lsoc_pkg::ADDR_INT_CTRL) begin
                rchk(lsoc_pkg::ADDR_STATUS, 8'h01, rows[i].ex);
            end else begin
                rchk(rows[i].wa, 8'hff, rows[i].ex);
            end
        end
        wr(lsoc_pkg::ADDR_INT_TRIM, 8'h15);
        mode <= 2'b00;
        ireq <= 1'b0;
        ereq <= 1'b0;
        repeat (10) @(posedge clk);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h01, 8'h00);
        repeat (30) @(posedge clk);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h01, 8'h01);
        wr(lsoc_pkg::ADDR_INT_TRIM, 8'h2a);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h01, 8'h00);
        chk({7'h00, trim === 7'h2a}, 8'h00);
        repeat (lsoc_pkg::COMMIT_CYC + 4) @(posedge clk);
        chk({1'b0, trim}, 8'h2a);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h01, 8'h01);
        wr(lsoc_pkg::ADDR_INT_CTRL, 8'h1a);
        tick(512, 8'd64, 8'd2);
        wr(lsoc_pkg::ADDR_INT_CTRL, 8'h12);
        tick(256, 8'd0, 8'd1);
        wr(lsoc_pkg::ADDR_INT_CTRL, 8'h0a);
        tick(256, 8'd32, 8'd0);
        wr(lsoc_pkg::ADDR_INT_CTRL, 8'h02);
        do_reset(1'b0);
        rchk(lsoc_pkg::ADDR_INT_CTRL, 8'hff, 8'h02);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h01, 8'h01);
        wr(lsoc_pkg::ADDR_INT_CTRL, 8'h82);
        ireq <= 1'b1;
        repeat (40) @(posedge clk);
        do_reset(1'b0);
        ireq <= 1'b0;
        rchk(lsoc_pkg::ADDR_INT_CTRL, 8'hff, 8'h00);
        do_reset(1'b1);
        rchk(lsoc_pkg::ADDR_INT_TRIM, 8'hff, 8'h40);
        rchk(lsoc_pkg::ADDR_INT_CTRL, 8'hff, 8'h00);
        // crystal across both pads, then external clock on the input pad
        wr(lsoc_pkg::ADDR_EXT_CTRL, 8'h0e);
        repeat (40) @(posedge clk);
        #1 ne32 = 0;
        repeat (64) @(posedge clk);
        #1 chk(8'(ne32), 8'd8);
        chk({7'h00, opad_oe}, 8'h01);
        chk({7'h00, ipad_oe}, 8'h00);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h02, 8'h02);
        wr(lsoc_pkg::ADDR_EXT_CTRL, 8'h02);
        repeat (4) @(posedge clk);
        chk({7'h00, opad_oe}, 8'h00);
        wr(lsoc_pkg::ADDR_EVT_CTRL, 8'h01);
        wr(lsoc_pkg::ADDR_CFD_CTRL, 8'h01);
        halt <= 1'b1;
        for (int k = 0; k < 200 && wk == 0; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        #1 chk(8'(wk), 8'h01);
        chk({7'h00, safe}, 8'h01);
        chk({7'h00, fev}, 8'h00);
        chk({7'h00, xo ^ pad}, 8'h01);
        chk({7'h00, ev_seen != 0}, 8'h01);
        rchk(lsoc_pkg::ADDR_STATUS, 8'h0c, 8'h0c);
        give_verdict;
    end
endmodule
